// ### pkg/sdt_pkg.sv
// shared constants and types for the serial debug, time-out and tag block
package sdt_pkg;
    // serial time-out, in target serial clock cycles
    localparam logic [9:0] TIMEOUT_CYC = 10'h200;
    // low time after a falling edge beyond which the low is a sync request
    localparam logic [7:0] SYNC_DETECT_CYC = 8'h80;
    // pause before the sync response, lets the host drop its speedup pulse
    localparam logic [7:0] SYNC_DELAY_CYC = 8'h10;
    // low time of the sync response
    localparam logic [7:0] SYNC_LOW_CYC = 8'h80;
    // instruction queue depth and tag field layout
    localparam int QUEUE_DEPTH = 3;
    localparam int TAG_W = 2;
    localparam int TAG_LO_BIT = 0;
    localparam int TAG_HI_BIT = 1;
    // handshake is off after system reset
    localparam logic ACK_EN_RESET = 1'b0;

    // single-step sequencer states
    typedef enum logic [2:0] {
        STEP_FW = 3'h1,
        STEP_RUN = 3'h2,
        STEP_STACK = 3'h4
    } sdt_step_t;

    // serial pin receive and sync response states
    typedef enum logic [5:0] {
        SYN_IDLE = 6'h01,
        SYN_LOW = 6'h02,
        SYN_WAIT = 6'h04,
        SYN_DELAY = 6'h08,
        SYN_DRIVE = 6'h10,
        SYN_SPEED = 6'h20
    } sdt_sync_t;
endpackage : sdt_pkg

// ### pkg/sdt_tag_if.sv
// carrier between the core and the tag pin sampler
`timescale 1ns/10ps
`default_nettype none
interface sdt_tag_if;
    logic external_bus_clock;
    logic pinHi;
    logic pinLo;
    logic lowEn;
    logic tagOn;
    logic high_tag_input;
    logic low_tag_input;
    modport sampler (input external_bus_clock, input pinHi, input pinLo, input lowEn, input tagOn,
        output high_tag_input, output low_tag_input);
    modport core (output external_bus_clock, output pinHi, output pinLo, output lowEn, output tagOn,
        input high_tag_input, input low_tag_input);
endinterface : sdt_tag_if
`default_nettype wire

// ### src/sdt_tag_sampler.sv
// samples the two tag pins at the falling edge of the external bus clock
`timescale 1ns/10ps
`default_nettype none
module sdt_tag_sampler (
    input wire logic clk,
    input wire logic rst_n,
    sdt_tag_if.sampler tagBus
);
    logic eclkPrev;
    logic high_tag_input;
    logic low_tag_input;
    logic eclkFall;
    logic sampleNow;

    // each pin is judged on its own; a low level asks for a tag
    assign eclkFall = eclkPrev & ~tagBus.external_bus_clock;
    assign sampleNow = eclkFall & tagBus.tagOn;
    assign tagBus.high_tag_input = high_tag_input;
    assign tagBus.low_tag_input = low_tag_input;

    // low half only counts while the low-byte strobe is enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eclkPrev <= 1'b0;
            high_tag_input <= 1'b0;
            low_tag_input <= 1'b0;
        end else begin
            eclkPrev <= tagBus.external_bus_clock;
            if (sampleNow) begin
                high_tag_input <= ~tagBus.pinHi;
                low_tag_input <= ~tagBus.pinLo & tagBus.lowEn;
            end
        end
    end

    a_tag_hi_sample: assert property (@(posedge clk) disable iff (!rst_n)
        sampleNow |=> high_tag_input == !$past(tagBus.pinHi))
        else $error("high tag not taken from pin at bus clock fall");
    a_tag_lo_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (sampleNow && !tagBus.lowEn) |=> !low_tag_input)
        else $error("low tag taken while low strobe disabled");
endmodule : sdt_tag_sampler
`default_nettype wire

// ### src/sdt_sync_timer.sv
// serial pin edge timing: bit versus sync, time-out and sync response
`timescale 1ns/10ps
`default_nettype none
module sdt_sync_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinIn,
    input wire logic listenEn,
    input wire logic cmdBusy,
    input wire logic suspend,
    input wire logic rearm,
    input wire logic clearReq,
    output logic softReset,
    output logic pinOut,
    output logic pinOe
);
    sdt_pkg::sdt_sync_t st;
    sdt_pkg::sdt_sync_t next_st;
    logic pinPrev;
    logic [9:0] gapCnt;
    logic [7:0] lowCnt;
    logic [7:0] seqCnt;
    logic newFall;
    logic syncHit;
    logic gapExpired;
    logic responding;

    assign responding = (st == sdt_pkg::SYN_DELAY) | (st == sdt_pkg::SYN_DRIVE)
        | (st == sdt_pkg::SYN_SPEED);
    assign newFall = pinPrev & ~pinIn & listenEn & (st == sdt_pkg::SYN_IDLE);
    assign syncHit = (st == sdt_pkg::SYN_LOW) & ~pinIn
        & (lowCnt == sdt_pkg::SYNC_DETECT_CYC);
    // a sync wait never times out, the counter is only judged while idle or in a bit's low time
    assign gapExpired = cmdBusy & ~suspend & ~newFall & ~rearm
        & ((st == sdt_pkg::SYN_IDLE) | (st == sdt_pkg::SYN_LOW))
        & (gapCnt == sdt_pkg::TIMEOUT_CYC - 10'h001);

    // next state; clock restarts cannot land inside our own response
    always_comb begin
        next_st = st;
        unique case (st)
            sdt_pkg::SYN_IDLE: if (newFall) next_st = sdt_pkg::SYN_LOW;
            sdt_pkg::SYN_LOW: begin
                if (pinIn) next_st = sdt_pkg::SYN_IDLE;
                else if (syncHit) next_st = sdt_pkg::SYN_WAIT;
            end
            sdt_pkg::SYN_WAIT: if (pinIn) next_st = sdt_pkg::SYN_DELAY;
            sdt_pkg::SYN_DELAY: begin
                if (seqCnt == sdt_pkg::SYNC_DELAY_CYC - 8'h01) next_st = sdt_pkg::SYN_DRIVE;
            end
            sdt_pkg::SYN_DRIVE: begin
                if (seqCnt == sdt_pkg::SYNC_LOW_CYC - 8'h01) next_st = sdt_pkg::SYN_SPEED;
            end
            sdt_pkg::SYN_SPEED: next_st = sdt_pkg::SYN_IDLE;
        endcase
        if ((clearReq || !listenEn) && !responding) next_st = sdt_pkg::SYN_IDLE;
    end

    // state, edge history and the sync sequencing counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= sdt_pkg::SYN_IDLE;
            pinPrev <= 1'b1;
            lowCnt <= 8'h00;
            seqCnt <= 8'h00;
        end else begin
            st <= next_st;
            pinPrev <= pinIn;
            lowCnt <= (st == sdt_pkg::SYN_LOW) ? lowCnt + 8'h01 : 8'h00;
            seqCnt <= (next_st != st) ? 8'h00 : seqCnt + 8'h01;
        end
    end

    // gap counter restarts on each falling edge seen while idle and listening, and on a handshake pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gapCnt <= sdt_pkg::TIMEOUT_CYC;
        end else if (newFall || rearm) begin
            gapCnt <= 10'h000;
        end else if (!suspend && gapCnt != sdt_pkg::TIMEOUT_CYC) begin
            gapCnt <= gapCnt + 10'h001;
        end
    end

    // pin drive follows the state being entered so it lines up with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            softReset <= 1'b0;
            pinOe <= 1'b0;
            pinOut <= 1'b0;
        end else begin
            softReset <= gapExpired | syncHit | clearReq;
            pinOe <= (next_st == sdt_pkg::SYN_DRIVE) | (next_st == sdt_pkg::SYN_SPEED);
            pinOut <= next_st == sdt_pkg::SYN_SPEED;
        end
    end

    a_sync_no_timeout: assert property (@(posedge clk) disable iff (!rst_n)
        (st == sdt_pkg::SYN_WAIT && !pinIn && !clearReq && listenEn)
        |=> st == sdt_pkg::SYN_WAIT && !softReset)
        else $error("sync wait left without a rising edge");
    a_sync_delay_len: assert property (@(posedge clk) disable iff (!rst_n)
        (st == sdt_pkg::SYN_WAIT && pinIn && !clearReq && listenEn)
        |=> st == sdt_pkg::SYN_DELAY ##16 (st == sdt_pkg::SYN_DRIVE && pinOe && !pinOut))
        else $error("sync response not started 16 cycles after release");
    a_sync_release: assert property (@(posedge clk) disable iff (!rst_n)
        (st == sdt_pkg::SYN_DRIVE && seqCnt == 8'h7F && pinOe && !pinOut)
        |=> (pinOe && pinOut) ##1 !pinOe)
        else $error("sync response missing speedup pulse or release");
    a_timeout_cause: assert property (@(posedge clk) disable iff (!rst_n)
        softReset |-> ($past(gapCnt) == 10'h1FF && $past(cmdBusy) && !$past(suspend))
        || $past(syncHit) || $past(clearReq))
        else $error("soft reset without its cause");
endmodule : sdt_sync_timer
`default_nettype wire

// ### src/sdt_top.sv
// serial debug target: single step, instruction tags, time-out and soft reset
`timescale 1ns/10ps
`default_nettype none
module sdt_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dbgPinIn,
    output logic dbgPinOut,
    output logic dbgPinOe,
    input wire logic strobePinIn,
    input wire logic extBusClk,
    input wire logic lowStrobeEn,
    input wire logic bgActive,
    input wire logic cmdBusy,
    input wire logic readWait,
    input wire logic ackReq,
    input wire logic ackEnableCmd,
    input wire logic ackDisableCmd,
    input wire logic singleStepCmd,
    input wire logic tagAndGoCmd,
    input wire logic waitRestart,
    input wire logic stopRestart,
    input wire logic irqPending,
    input wire logic userInstrDone,
    input wire logic stackDone,
    input wire logic queueLoad,
    input wire logic queueShift,
    input wire logic headIssue,
    output logic firmwareExit,
    output logic stackReq,
    output logic bgEnter,
    output logic execBlock,
    output logic ackPulse,
    output logic ackEnabled,
    output logic taggingOn,
    output logic softReset
);
    sdt_pkg::sdt_step_t stepSt;
    sdt_pkg::sdt_step_t next_stepSt;
    logic bgPrev;
    logic ackEn;
    logic next_ackEn;
    logic next_tagging;
    logic [sdt_pkg::TAG_W-1:0] qTag [sdt_pkg::QUEUE_DEPTH];
    logic [sdt_pkg::QUEUE_DEPTH-1:0] qValid;
    logic [sdt_pkg::TAG_W-1:0] loadTag;
    logic bgRise;
    logic cmdOk;
    logic stepGo;
    logic tag_and_go_command;
    logic clkRestart;
    logic headTagged;
    logic tagTrap;
    logic stepDone;
    logic suspend;
    logic timerPinOut;
    logic timerPinOe;
    logic timerSoftReset;

    sdt_tag_if tagBus ();

    // command strobes count only while no tagging session runs
    assign bgRise = bgActive & ~bgPrev;
    assign cmdOk = ~taggingOn;
    assign stepGo = singleStepCmd & cmdOk & bgActive & (stepSt == sdt_pkg::STEP_FW);
    assign tag_and_go_command = tagAndGoCmd & cmdOk & bgActive;
    assign clkRestart = waitRestart | stopRestart;

    // read data wait is exempt from time-out only with the handshake on
    assign suspend = ackEn & readWait;

    // tag pins: debug pin carries the high tag, strobe pin the low tag
    assign tagBus.external_bus_clock = extBusClk;
    assign tagBus.pinHi = dbgPinIn;
    assign tagBus.pinLo = strobePinIn;
    assign tagBus.lowEn = lowStrobeEn;
    assign tagBus.tagOn = taggingOn;
    assign loadTag = taggingOn ? {tagBus.high_tag_input, tagBus.low_tag_input} : 2'h0;

    // a tagged word at the head is not executed; background is entered
    assign headTagged = qValid[0] & (|qTag[0]);
    assign tagTrap = headIssue & headTagged;
    assign stepDone = ((stepSt == sdt_pkg::STEP_RUN) & userInstrDone)
        | ((stepSt == sdt_pkg::STEP_STACK) & stackDone);

    sdt_tag_sampler u_tag (
        .clk(clk),
        .rst_n(rst_n),
        .tagBus(tagBus.sampler)
    );

    // the pin is not watched for commands while it serves as a tag input
    sdt_sync_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(dbgPinIn),
        .listenEn(cmdOk),
        .cmdBusy(cmdBusy),
        .suspend(suspend),
        .rearm(ackPulse),
        .clearReq(clkRestart),
        .softReset(timerSoftReset),
        .pinOut(timerPinOut),
        .pinOe(timerPinOe)
    );
    assign dbgPinOut = timerPinOut;
    assign dbgPinOe = timerPinOe;
    assign softReset = timerSoftReset;

    // single-step sequencer
    always_comb begin
        next_stepSt = stepSt;
        unique case (stepSt)
            sdt_pkg::STEP_FW: begin
                if (stepGo && irqPending) next_stepSt = sdt_pkg::STEP_STACK;
                else if (stepGo) next_stepSt = sdt_pkg::STEP_RUN;
            end
            sdt_pkg::STEP_RUN: if (userInstrDone) next_stepSt = sdt_pkg::STEP_FW;
            sdt_pkg::STEP_STACK: if (stackDone) next_stepSt = sdt_pkg::STEP_FW;
        endcase
    end

    // handshake enable: clock restarts win over a same-cycle enable
    always_comb begin
        next_ackEn = ackEn;
        if (ackEnableCmd && cmdOk) next_ackEn = 1'b1;
        if (ackDisableCmd && cmdOk) next_ackEn = 1'b0;
        if (clkRestart) next_ackEn = 1'b0;
    end

    // tagging starts on tag-and-go and ends when background mode begins
    always_comb begin
        next_tagging = taggingOn;
        if (tag_and_go_command) next_tagging = 1'b1;
        if (bgRise) next_tagging = 1'b0;
    end

    // control state and outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stepSt <= sdt_pkg::STEP_FW;
            bgPrev <= 1'b0;
            ackEn <= sdt_pkg::ACK_EN_RESET;
            ackEnabled <= sdt_pkg::ACK_EN_RESET;
            taggingOn <= 1'b0;
        end else begin
            stepSt <= next_stepSt;
            bgPrev <= bgActive;
            ackEn <= next_ackEn;
            ackEnabled <= next_ackEn;
            taggingOn <= next_tagging;
        end
    end

    // strobes toward the cpu, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firmwareExit <= 1'b0;
            stackReq <= 1'b0;
            bgEnter <= 1'b0;
            execBlock <= 1'b0;
            ackPulse <= 1'b0;
        end else begin
            firmwareExit <= next_stepSt == sdt_pkg::STEP_RUN;
            stackReq <= next_stepSt == sdt_pkg::STEP_STACK;
            bgEnter <= stepDone | tagTrap;
            execBlock <= tagTrap;
            ackPulse <= ackReq & ackEn & cmdOk;
        end
    end

    // tag queue: entries move toward the head; flushed on background entry
    generate
        for (genvar i = 0; i < sdt_pkg::QUEUE_DEPTH; i++) begin : g_q
            logic [sdt_pkg::TAG_W-1:0] srcTag;
            logic srcValid;
            logic takeNew;
            if (i == sdt_pkg::QUEUE_DEPTH - 1) begin : g_tail
                assign srcTag = loadTag;
                assign srcValid = queueLoad;
                assign takeNew = queueShift | queueLoad;
            end else begin : g_body
                assign srcTag = qTag[i+1];
                assign srcValid = qValid[i+1];
                assign takeNew = queueShift;
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    qTag[i] <= 2'h0;
                    qValid[i] <= 1'b0;
                end else if (bgRise || tagTrap) begin
                    qTag[i] <= 2'h0;
                    qValid[i] <= 1'b0;
                end else if (takeNew) begin
                    qTag[i] <= srcTag;
                    qValid[i] <= srcValid;
                end
            end
        end
    endgenerate

    // single step: one instruction or one stacking, then back to firmware
    a_step_run: assert property (@(posedge clk) disable iff (!rst_n)
        (stepGo && !irqPending) |=> firmwareExit && !stackReq)
        else $error("single step did not leave firmware");
    a_exit_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (stepSt == sdt_pkg::STEP_RUN && !userInstrDone)
        |=> firmwareExit && !stackReq)
        else $error("stepped instruction dropped early");
    a_step_return: assert property (@(posedge clk) disable iff (!rst_n)
        (stepSt == sdt_pkg::STEP_RUN && userInstrDone) |=> bgEnter && !firmwareExit)
        else $error("single step did not return after one instruction");
    a_step_stack: assert property (@(posedge clk) disable iff (!rst_n)
        (stepGo && irqPending) |=> stackReq && !firmwareExit)
        else $error("pending interrupt ran a user instruction");
    a_stack_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (stepSt == sdt_pkg::STEP_STACK && !stackDone)
        |=> stackReq && !firmwareExit)
        else $error("stacking request dropped early");
    a_stack_return: assert property (@(posedge clk) disable iff (!rst_n)
        (stepSt == sdt_pkg::STEP_STACK && stackDone)
        |=> bgEnter && !stackReq)
        else $error("stacking did not return to firmware");

    // tags: session start, queue tail load, trap and session end
    a_tag_start: assert property (@(posedge clk) disable iff (!rst_n)
        (tagAndGoCmd && bgActive && bgPrev && !taggingOn)
        |=> taggingOn)
        else $error("tag-and-go did not start tagging");
    a_tag_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (taggingOn && !bgRise)
        |=> taggingOn)
        else $error("tagging ended outside background entry");
    a_queue_load: assert property (@(posedge clk) disable iff (!rst_n)
        (queueLoad && !queueShift && !bgRise && !tagTrap)
        |=> qValid[sdt_pkg::QUEUE_DEPTH-1])
        else $error("loaded word missing at queue tail");
    a_tag_trap: assert property (@(posedge clk) disable iff (!rst_n)
        (headIssue && headTagged) |=> bgEnter && execBlock)
        else $error("tagged head executed");
    a_trap_none: assert property (@(posedge clk) disable iff (!rst_n)
        (headIssue && !headTagged)
        |=> !execBlock)
        else $error("untagged head suppressed");
    a_queue_flush: assert property (@(posedge clk) disable iff (!rst_n)
        (bgRise || tagTrap)
        |=> !(|qValid))
        else $error("queue kept entries after a trap or background entry");
    a_tag_off_bg: assert property (@(posedge clk) disable iff (!rst_n)
        (bgActive && !$past(bgActive)) |=> !taggingOn)
        else $error("tagging survives background entry");
    a_cmd_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (taggingOn && stepSt == sdt_pkg::STEP_FW) |=> !firmwareExit && !stackReq)
        else $error("command taken while tagging");
    a_ack_cmd_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (taggingOn && !clkRestart)
        |=> ackEnabled == $past(ackEnabled))
        else $error("handshake command taken while tagging");

    // handshake: pulse only when enabled and not tagging
    a_ack_grant: assert property (@(posedge clk) disable iff (!rst_n)
        (ackReq && ackEnabled && !taggingOn)
        |=> ackPulse)
        else $error("enabled handshake pulse not issued");
    a_ack_off: assert property (@(posedge clk) disable iff (!rst_n)
        (ackReq && !ackEnabled)
        |=> !ackPulse)
        else $error("handshake pulse while disabled");
    a_ack_enable: assert property (@(posedge clk) disable iff (!rst_n)
        (ackEnableCmd && !ackDisableCmd && !taggingOn && !clkRestart)
        |=> ackEnabled)
        else $error("handshake enable command not taken");
    a_ack_no_tag: assert property (@(posedge clk) disable iff (!rst_n)
        taggingOn |=> !ackPulse)
        else $error("handshake pulse while tagging");
    a_ack_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (waitRestart || stopRestart) |=> !ackEnabled && softReset)
        else $error("clock restart left handshake enabled");
endmodule : sdt_top
`default_nettype wire

// ### verification/sdt_host_pod.sv
// host debug pod model: pulls the serial debug pin low, then a speedup pulse
`timescale 1ns/10ps
`default_nettype none
module sdt_host_pod (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [9:0] lowLen,
    output logic podOe,
    output logic podOut
);
    logic [9:0] cnt;

    // every transfer opens with a fall; short lows are bits, long ones sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            podOe <= 1'b0;
            podOut <= 1'b1;
            cnt <= 10'h000;
        end else if (go && !podOe) begin
            podOe <= 1'b1;
            podOut <= 1'b0;
            cnt <= lowLen;
        end else if (podOe && !podOut) begin
            if (cnt <= 10'h001) begin
                podOut <= 1'b1; // one-cycle speedup pulse
            end else begin
                cnt <= cnt - 10'h001;
            end
        end else begin
            podOe <= 1'b0; // released: the pull-up owns the line again
        end
    end
endmodule : sdt_host_pod
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the serial debug target
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rst_n, strobePinIn, extBusClk, lowStrobeEn, bgActive, cmdBusy, readWait;
    logic ackReq, ackEnableCmd, ackDisableCmd, singleStepCmd, tagAndGoCmd, waitRestart;
    logic stopRestart, irqPending, userInstrDone, stackDone, queueLoad, queueShift, headIssue;
    logic go, tagHiDrv, podOe, podOut, sawOe, hit;
    logic dbgPinIn, dbgPinOut, dbgPinOe, firmwareExit, stackReq, bgEnter, execBlock;
    logic ackPulse, ackEnabled, taggingOn, softReset;
    logic [9:0] lowLen;
    logic [2:0] r;
    logic [31:0] rv;
    int mismatches, testsRun, seed, cnt, first, n, lo, hi;

    sdt_top u_dut (
        .clk(clk), .rst_n(rst_n), .dbgPinIn(dbgPinIn), .dbgPinOut(dbgPinOut),
        .dbgPinOe(dbgPinOe), .strobePinIn(strobePinIn), .extBusClk(extBusClk),
        .lowStrobeEn(lowStrobeEn), .bgActive(bgActive), .cmdBusy(cmdBusy),
        .readWait(readWait), .ackReq(ackReq), .ackEnableCmd(ackEnableCmd),
        .ackDisableCmd(ackDisableCmd), .singleStepCmd(singleStepCmd),
        .tagAndGoCmd(tagAndGoCmd), .waitRestart(waitRestart), .stopRestart(stopRestart),
        .irqPending(irqPending), .userInstrDone(userInstrDone), .stackDone(stackDone),
        .queueLoad(queueLoad), .queueShift(queueShift), .headIssue(headIssue),
        .firmwareExit(firmwareExit), .stackReq(stackReq), .bgEnter(bgEnter),
        .execBlock(execBlock), .ackPulse(ackPulse), .ackEnabled(ackEnabled),
        .taggingOn(taggingOn), .softReset(softReset)
    );

    sdt_host_pod u_pod (
        .clk(clk), .rst_n(rst_n), .go(go), .lowLen(lowLen), .podOe(podOe), .podOut(podOut)
    );

    // wired pin: device, then pod, else pull-up or the bench's tag level
    assign dbgPinIn = dbgPinOe ? dbgPinOut : (podOe ? podOut : tagHiDrv);

    // free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task finishTest;
        if (mismatches == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finishTest

    // tag expectation: a low pin tags, the low half only with the strobe on
    function automatic logic expHit(input logic [2:0] pins);
        return !pins[1] || (!pins[0] && pins[2]);
    endfunction : expHit

    // one-cycle strobe, launched and dropped on falling edges
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    // counts soft resets over a fixed span, notes the first and any device drive
    task watch(input int len);
        cnt = 0;
        first = 0;
        sawOe = 1'b0;
        for (int k = 1; k <= len; k++) begin
            @(negedge clk);
            if (dbgPinOe === 1'b1) sawOe = 1'b1;
            if (softReset === 1'b1) begin
                if (cnt == 0) first = k;
                cnt++;
            end
        end
    endtask : watch

    // hang guard: a stuck run still reaches the verdict
    initial begin
        #100000;
        mismatches++;
        finishTest;
    end

    initial begin
        seed = 32'hFD24;
        mismatches = 0;
        testsRun = 0;
        rst_n = 1'b0;
        strobePinIn = 1'b1;
        tagHiDrv = 1'b1;
        lowLen = 10'h000;
        {extBusClk, lowStrobeEn, bgActive, cmdBusy, readWait, ackReq, go} = '0;
        {ackEnableCmd, ackDisableCmd, singleStepCmd, tagAndGoCmd, waitRestart} = '0;
        {stopRestart, irqPending, userInstrDone, stackDone, queueLoad, queueShift} = '0;
        headIssue = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({dbgPinOe, firmwareExit, stackReq, bgEnter, execBlock, ackPulse}, 0);
        check({ackEnabled, taggingOn, softReset}, 0);

        // sync request with a command open: one soft reset, never a time-out
        rv = $random(seed);
        lowLen = 10'h258 + {2'h0, rv[7:0]};
        cmdBusy = 1'b1;
        pulse(go);
        watch(lowLen - 10'h001);
        cmdBusy = 1'b0;
        check(cnt, 1);
        check(first >= 128 && first <= 135, 1);
        n = 0;
        while (dbgPinOe !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(n >= 17 && n <= 19, 1);
        if (n >= 40) finishTest;
        lo = 0;
        while (dbgPinOe === 1'b1 && dbgPinOut === 1'b0 && lo < 300) begin
            @(negedge clk);
            lo++;
        end
        hi = 0;
        while (dbgPinOe === 1'b1 && dbgPinOut === 1'b1 && hi < 5) begin
            @(negedge clk);
            hi++;
        end
        check(lo, 128);
        check(hi, 1);
        check(dbgPinOe, 0);

        // single bits left hanging, plain and as unread read data
        for (int b = 0; b < 2; b++) begin
            rv = $random(seed);
            lowLen = 10'h00A + {4'h0, rv[5:0]};
            readWait = b[0];
            cmdBusy = 1'b1;
            pulse(go);
            watch(600);
            check(cnt, 1);
            check(first >= 510 && first <= 518, 1);
            check(sawOe, 0);
            {cmdBusy, readWait} = 2'h0;
        end

        // handshake on: wait suspended until the pulse, then the count rearms
        pulse(ackEnableCmd);
        check(ackEnabled, 1);
        {readWait, cmdBusy} = 2'h3;
        lowLen = 10'h014;
        pulse(go);
        watch(700);
        check(cnt, 0);
        ackReq = 1'b1;
        readWait = 1'b0;
        @(negedge clk);
        ackReq = 1'b0;
        check(ackPulse, 1);
        // host side leaves the data unread past its 512-cycle allowance
        watch(600);
        cmdBusy = 1'b0;
        check(cnt, 1);
        check(first >= 509 && first <= 518, 1);

        // clock restarts after wait and after stop
        for (int w = 0; w < 2; w++) begin
            pulse(ackEnableCmd);
            if (w == 0) pulse(waitRestart);
            else pulse(stopRestart);
            check(ackEnabled, 0);
            check(softReset, 1);
        end
        pulse(ackEnableCmd);

        // single step, without and with an interrupt pending
        bgActive = 1'b1;
        for (int s = 0; s < 2; s++) begin
            irqPending = s[0];
            pulse(singleStepCmd);
            check(firmwareExit, !s[0]);
            check(stackReq, s[0]);
            rv = $random(seed);
            repeat (1 + rv[2:0]) @(negedge clk);
            if (s == 0) pulse(userInstrDone);
            else pulse(stackDone);
            check({firmwareExit, stackReq, bgEnter}, 3'h1);
            @(negedge clk);
            check(bgEnter, 0);
        end
        irqPending = 1'b0;

        // tagging: every pin pair first, then random pins and strobe modes
        for (int i = 0; i < 12; i++) begin
            rv = $random(seed);
            r = (i < 4) ? {1'b1, i[1:0]} : rv[2:0];
            pulse(tagAndGoCmd);
            bgActive = 1'b0;
            check(taggingOn, 1);
            if (i == 0) begin
                pulse(ackReq);
                check(ackPulse, 0);
                pulse(ackDisableCmd);
                check(ackEnabled, 1);
            end
            lowStrobeEn = r[2];
            tagHiDrv = r[1];
            strobePinIn = r[0];
            extBusClk = 1'b1;
            repeat (2) @(negedge clk);
            extBusClk = 1'b0;
            repeat (2) @(negedge clk);
            tagHiDrv = 1'b1;
            strobePinIn = 1'b1;
            pulse(queueLoad);
            queueShift = 1'b1; // two shifts back to back, strobe held
            repeat (2) @(negedge clk);
            queueShift = 1'b0;
            pulse(headIssue);
            hit = expHit(r);
            check({execBlock, bgEnter}, {hit, hit});
            bgActive = 1'b1;
            repeat (2) @(negedge clk);
            check(taggingOn, 0);
        end
        finishTest;
    end
endmodule : tb
`default_nettype wire
